// ===== pkg/cbpsc_consts.vh
`ifndef CBPSC_CONSTS_VH
`define CBPSC_CONSTS_VH
`define CBPSC_IDX_PART_ID      8'h05
`define CBPSC_IDX_BLK_LEN      8'h06
`define CBPSC_IDX_CTRL         8'h00
`define CBPSC_IDX_OUT_EN       8'h01
`define CBPSC_IDX_STOPPABLE    8'h02
`define CBPSC_BLK_LEN_RST      8'h07
`define CBPSC_CTRL_RST         8'h07
`define CBPSC_OUT_EN_RST       8'hff
`define CBPSC_STOPPABLE_RST    8'h00
`define CBPSC_BIT_PD_FLOAT     7
`define CBPSC_BIT_STOP_FLOAT   6
`define CBPSC_ADDR_WR          8'hdc
`define CBPSC_ADDR_RD          8'hdd
`define CBPSC_CLK_HZ           40000000
`define CBPSC_LOCK_US          1000
`define CBPSC_LOCK_CYC         ((`CBPSC_CLK_HZ / 1000000) * `CBPSC_LOCK_US)
`define CBPSC_RESTART_LAST     3'h1
`endif

// ===== src/cbpsc_sync2.v
`timescale 1ns/10ps
// Two-stage synchroniser; first stage read only by the second
module cbpsc_sync2 #(
  parameter RST_VAL = 1'b1
) (
  sys_clk,
  rst_b,
  d,
  q
);
  input  wire sys_clk;
  input  wire rst_b;
  input  wire d;
  output wire q;
  reg s1_r;
  reg s2_r;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule // cbpsc_sync2

// ===== src/cbpsc_top.v
`timescale 1ns/10ps
`include "cbpsc_consts.vh"
module cbpsc_top #(
  parameter       NOUT     = 8,
  parameter [7:0] PART_ID  = 8'h5a, // Arbitrary identifier value
  parameter       LOCK_CYC = `CBPSC_LOCK_CYC
) (
  input  wire            sys_clk,
  input  wire            rst_b,
  input  wire            power_down_n,
  input  wire            output_halt_n,
  input  wire            ref_clk_valid,
  input  wire            out_clk,
  input  wire            reg_wr,
  input  wire            reg_rd,
  input  wire [7:0]      reg_slave_addr,
  input  wire [7:0]      reg_idx,
  input  wire [7:0]      reg_wdata,
  output reg  [7:0]      reg_rdata,
  output reg             reg_ack,
  output wire [NOUT-1:0] clk_out_true,
  output wire [NOUT-1:0] clk_out_true_oe,
  output wire [NOUT-1:0] clk_out_comp,
  output wire [NOUT-1:0] clk_out_comp_oe,
  output wire            pll_enable,
  output wire            pll_locked
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  wire pd_s;
  wire halt_s;
  wire oclk_s;
  wire refv_s;
  cbpsc_sync2 #(.RST_VAL(1'b1)) u_pd (.sys_clk(sys_clk), .rst_b(rst_b),
    .d(power_down_n), .q(pd_s));
  cbpsc_sync2 #(.RST_VAL(1'b1)) u_halt (.sys_clk(sys_clk), .rst_b(rst_b),
    .d(output_halt_n), .q(halt_s));
  cbpsc_sync2 #(.RST_VAL(1'b0)) u_oclk (.sys_clk(sys_clk), .rst_b(rst_b),
    .d(out_clk), .q(oclk_s));
  cbpsc_sync2 #(.RST_VAL(1'b0)) u_refv (.sys_clk(sys_clk), .rst_b(rst_b),
    .d(ref_clk_valid), .q(refv_s));

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] blk_len_r;
  reg [7:0] ctrl_r;
  reg [7:0] out_en_r;
  reg [7:0] stoppable_r;
  wire wr_hit = reg_wr && (reg_slave_addr == `CBPSC_ADDR_WR);
  wire rd_hit = reg_rd && (reg_slave_addr == `CBPSC_ADDR_RD);

  // Writes to the identifier or to unmapped indices are acked and dropped
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      blk_len_r   <= `CBPSC_BLK_LEN_RST;
      ctrl_r      <= `CBPSC_CTRL_RST;
      out_en_r    <= `CBPSC_OUT_EN_RST;
      stoppable_r <= `CBPSC_STOPPABLE_RST;
    end else if (wr_hit) begin
      case (reg_idx)
        `CBPSC_IDX_BLK_LEN:   blk_len_r   <= reg_wdata;
        `CBPSC_IDX_CTRL:      ctrl_r      <= reg_wdata;
        `CBPSC_IDX_OUT_EN:    out_en_r    <= reg_wdata;
        `CBPSC_IDX_STOPPABLE: stoppable_r <= reg_wdata;
        default:              ;
      endcase
    end
  end

  // Read data is held until the next addressed read
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
      reg_ack   <= 1'b0;
    end else begin
      reg_ack <= wr_hit || rd_hit;
      if (rd_hit) begin
        case (reg_idx)
          `CBPSC_IDX_PART_ID:   reg_rdata <= PART_ID;
          `CBPSC_IDX_BLK_LEN:   reg_rdata <= blk_len_r;
          `CBPSC_IDX_CTRL:      reg_rdata <= ctrl_r;
          `CBPSC_IDX_OUT_EN:    reg_rdata <= out_en_r;
          `CBPSC_IDX_STOPPABLE: reg_rdata <= stoppable_r;
          default:              reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  wire pd_float   = ctrl_r[`CBPSC_BIT_PD_FLOAT];
  wire stop_float = ctrl_r[`CBPSC_BIT_STOP_FLOAT];

  // ----------------------------------------------------------------
  // Output clock edge detect and debounce
  // ----------------------------------------------------------------
  reg oclk_d_r;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) oclk_d_r <= 1'b0;
    else        oclk_d_r <= oclk_s;
  end
  // Complementary output rises when the true clock falls
  wire comp_rise = oclk_d_r && !oclk_s;
  wire comp_fall = !oclk_d_r && oclk_s;

  // Pin level seen at the previous complementary rise
  reg pd_prev_r;
  reg halt_prev_r;
  reg pd_low_r;
  reg halt_act_r;
  reg parked_r;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pd_prev_r <= 1'b1;
      pd_low_r  <= 1'b0;
      parked_r  <= 1'b0;
    end else begin
      if (comp_rise) begin
        pd_prev_r <= pd_s;
        if (!pd_prev_r && !pd_s) pd_low_r <= 1'b1;
      end
      // Wake-up is not debounced so relock starts at once
      if (pd_s) pd_low_r <= 1'b0;
      if (comp_fall && pd_low_r) parked_r <= 1'b1;
      else if (!pd_low_r) parked_r <= 1'b0;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      halt_prev_r <= 1'b1;
      halt_act_r  <= 1'b0;
    end else if (comp_rise) begin
      halt_prev_r <= halt_s;
      // Stop qualifies only with reference running
      if (refv_s && !halt_prev_r && !halt_s) halt_act_r <= 1'b1;
      if (halt_prev_r && halt_s) halt_act_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // PLL sequencing and lock timer
  // ----------------------------------------------------------------
  // PLL drops in the same cycle that the parked levels reach the pins
  reg pll_en_r;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) pll_en_r <= 1'b1;
    else        pll_en_r <= !parked_r;
  end
  assign pll_enable = pll_en_r;
  reg [31:0] lock_cnt_r;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) lock_cnt_r <= 32'h0;
    else if (!pll_enable || !refv_s) lock_cnt_r <= 32'h0;
    else if (lock_cnt_r < LOCK_CYC) lock_cnt_r <= lock_cnt_r + 32'h1;
  end
  assign pll_locked = (lock_cnt_r >= LOCK_CYC);

  // ----------------------------------------------------------------
  // Stop and restart sequencing
  // ----------------------------------------------------------------
  // Restart waits whole periods so the first pulse is full width
  // All pairs share one state, so the stoppable ones stop and resume together
  localparam [1:0] ST_RUN     = 2'b00;
  localparam [1:0] ST_PEND    = 2'b01;
  localparam [1:0] ST_STOPPED = 2'b10;
  localparam [1:0] ST_RESUME  = 2'b11;

  reg [1:0] stop_st_r;
  reg [1:0] stop_st_nxt;
  reg [2:0] rst_cnt_r;
  reg [2:0] rst_cnt_nxt;
  always @* begin
    stop_st_nxt = stop_st_r;
    rst_cnt_nxt = rst_cnt_r;
    case (stop_st_r)
      ST_RUN: begin
        if (halt_act_r) stop_st_nxt = ST_PEND;
      end
      ST_PEND: begin
        // Stop lands right after the true clock has risen
        if (!halt_act_r)    stop_st_nxt = ST_RUN;
        else if (comp_fall) stop_st_nxt = ST_STOPPED;
      end
      ST_STOPPED: begin
        rst_cnt_nxt = 3'h0;
        if (!halt_act_r) stop_st_nxt = ST_RESUME;
      end
      ST_RESUME: begin
        if (halt_act_r) begin
          stop_st_nxt = ST_STOPPED;
          rst_cnt_nxt = 3'h0;
        end else if (comp_fall) begin
          if (rst_cnt_r == `CBPSC_RESTART_LAST) begin
            stop_st_nxt = ST_RUN;
            rst_cnt_nxt = 3'h0;
          end else begin
            rst_cnt_nxt = rst_cnt_r + 3'h1;
          end
        end
      end
      default: begin
        stop_st_nxt = ST_RUN;
        rst_cnt_nxt = 3'h0;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_st_r <= ST_RUN;
      rst_cnt_r <= 3'h0;
    end else begin
      stop_st_r <= stop_st_nxt;
      rst_cnt_r <= rst_cnt_nxt;
    end
  end

  wire stopped = (stop_st_r == ST_STOPPED) || (stop_st_r == ST_RESUME);
  // Float release drives high from the synced pin, not the debounced one;
  // the synchroniser still sets the floor on that latency
  wire stop_rel_drive = stopped && halt_s;
  wire stop_drive     = !stop_float || stop_rel_drive;

  // ----------------------------------------------------------------
  // Output pin drive
  // ----------------------------------------------------------------
  // Each pair owns its flops; priority is park, relock, disable, stop
  genvar g;
  generate
    for (g = 0; g < NOUT; g = g + 1) begin : g_out
      reg t_r;
      reg toe_r;
      reg c_r;
      reg coe_r;
      reg t_nxt;
      reg toe_nxt;
      reg c_nxt;
      reg coe_nxt;

      always @* begin
        t_nxt   = oclk_s;
        toe_nxt = 1'b1;
        c_nxt   = !oclk_s;
        coe_nxt = 1'b1;
        if (parked_r) begin
          t_nxt   = 1'b1;
          toe_nxt = !pd_float;
          c_nxt   = 1'b0;
          coe_nxt = 1'b0;
        end else if (!pll_locked && pd_float) begin
          // Drive high well before 300 us while PLL relocks
          t_nxt   = 1'b1;
          toe_nxt = 1'b1;
          c_nxt   = 1'b0;
          coe_nxt = 1'b1;
        end else if (!out_en_r[g]) begin
          t_nxt   = 1'b0;
          toe_nxt = 1'b0;
          c_nxt   = 1'b0;
          coe_nxt = 1'b0;
        end else if (stopped && stoppable_r[g]) begin
          // Float mode rests low; the pins are undriven then
          t_nxt   = stop_drive;
          toe_nxt = stop_drive;
          c_nxt   = 1'b0;
          coe_nxt = 1'b0;
        end
      end

      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          t_r   <= 1'b0;
          toe_r <= 1'b0;
          c_r   <= 1'b0;
          coe_r <= 1'b0;
        end else begin
          t_r   <= t_nxt;
          toe_r <= toe_nxt;
          c_r   <= c_nxt;
          coe_r <= coe_nxt;
        end
      end

      assign clk_out_true[g]    = t_r;
      assign clk_out_true_oe[g] = toe_r;
      assign clk_out_comp[g]    = c_r;
      assign clk_out_comp_oe[g] = coe_r;
    end
  endgenerate

endmodule // cbpsc_top

// ===== test/cbpsc_partner.sv
`timescale 1ns/10ps
module cbpsc_partner #(
  parameter HALF = 4
) (
  input  wire sys_clk,
  input  wire power_down_n,
  input  wire pll_enable,
  output reg  out_clk,
  output reg  ref_clk_valid
);
  int n = 0;
  initial out_clk = 1'b0;
  initial ref_clk_valid = 1'b1;
  // Reference only goes once the PLL is off, whether or not a stop is live
  always @(negedge sys_clk) begin
    n <= (n == HALF - 1) ? 0 : n + 1;
    if (n == HALF - 1) out_clk <= ~out_clk;
    ref_clk_valid <= power_down_n | pll_enable;
  end
endmodule // cbpsc_partner

// ===== test/cbpsc_asserts.sv
`timescale 1ns/10ps
module cbpsc_chk #(
  parameter       NOUT    = 8,
  parameter [7:0] PART_ID = 8'h5a
) (
  input wire            sys_clk,
  input wire            rst_b,
  input wire            power_down_n,
  input wire            reg_wr,
  input wire            reg_rd,
  input wire [7:0]      reg_slave_addr,
  input wire [7:0]      reg_idx,
  input wire [7:0]      reg_rdata,
  input wire            reg_ack,
  input wire [NOUT-1:0] clk_out_true,
  input wire [NOUT-1:0] clk_out_true_oe,
  input wire [NOUT-1:0] clk_out_comp_oe,
  input wire            pll_enable,
  input wire            pll_locked
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_rd;
    reg_rd && reg_slave_addr == 8'hdd;
  endsequence
  sequence s_wr;
    reg_wr && reg_slave_addr == 8'hdc;
  endsequence
  chk_ack_given: assert property ((s_rd or s_wr) |=> reg_ack)
    else $error("addressed request not acked");
  chk_ack_foreign: assert property (!(reg_rd && reg_slave_addr == 8'hdd) &&
    !(reg_wr && reg_slave_addr == 8'hdc) |=> !reg_ack) else $error("foreign ack");
  chk_id_value: assert property (s_rd ##0 reg_idx == 8'h05 |=> reg_rdata == PART_ID)
    else $error("identifier wrong");
  chk_park_first: assert property ($fell(pll_enable) |-> clk_out_comp_oe == '0)
    else $error("pll off before park");
  chk_pd_state: assert property (!pll_enable |-> clk_out_comp_oe == '0 &&
    (clk_out_true_oe & ~clk_out_true) == '0) else $error("bad park state");
  chk_pd_qualify: assert property ($fell(pll_enable) |-> !$past(power_down_n, 8))
    else $error("power-down taken too early");
  chk_pd_wake: assert property ($rose(power_down_n) && !pll_enable |->
    ##[1:1000] clk_out_true_oe != '0) else $error("outputs not driven on wake");
  chk_lock_time: assert property ($rose(pll_enable) |-> ##[1:1000] pll_locked)
    else $error("no lock");
endmodule // cbpsc_chk
bind cbpsc_top cbpsc_chk #(.NOUT(NOUT), .PART_ID(PART_ID)) i_chk (.sys_clk, .rst_b,
  .power_down_n, .reg_wr, .reg_rd, .reg_slave_addr, .reg_idx, .reg_rdata, .reg_ack,
  .clk_out_true, .clk_out_true_oe, .clk_out_comp_oe, .pll_enable, .pll_locked);

// ===== test/clock_buffer_power_stop_control_tb_top.sv
`timescale 1ns/10ps
module clock_buffer_power_stop_control_tb_top;
  reg        sys_clk = 1'b0;
  reg        rst_b = 1'b0;
  reg        power_down_n = 1'b1;
  reg        output_halt_n = 1'b1;
  reg        reg_wr = 1'b0;
  reg        reg_rd = 1'b0;
  reg  [7:0] reg_slave_addr = 8'h00;
  reg  [7:0] reg_idx = 8'h00;
  reg  [7:0] reg_wdata = 8'h00;
  wire       ref_ok, oclk, ack, pll_en, lock;
  wire [7:0] rdata, t, t_oe, c, c_oe;
  int        error_cnt = 0;
  int        checks_done = 0;
  int        k;
  initial forever #12.5 sys_clk = ~sys_clk;
  // Arbitrary identifier value; short lock count keeps the run brief
  cbpsc_top #(.PART_ID(8'h3c), .LOCK_CYC(20)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .power_down_n(power_down_n), .output_halt_n(output_halt_n), .ref_clk_valid(ref_ok),
    .out_clk(oclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_slave_addr(reg_slave_addr),
    .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_ack(ack),
    .clk_out_true(t), .clk_out_true_oe(t_oe), .clk_out_comp(c), .clk_out_comp_oe(c_oe),
    .pll_enable(pll_en), .pll_locked(lock));
  cbpsc_partner i_far (.sys_clk(sys_clk), .power_down_n(power_down_n), .pll_enable(pll_en),
    .out_clk(oclk), .ref_clk_valid(ref_ok));
  task automatic chk(input string nm, input [7:0] exp, input [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Ack and data are sampled one cycle after the strobe, before it drops
  task automatic acc(input bit rd, input [7:0] sa, input [7:0] ix, input [7:0] wd,
                     input bit ea, input [7:0] ed);
    reg_rd = rd;
    reg_wr = ~rd;
    reg_slave_addr = sa;
    reg_idx = ix;
    reg_wdata = wd;
    @(negedge sys_clk);
    chk("ack", {7'h0, ea}, {7'h0, ack});
    if (rd && ea) chk("rdata", ed, rdata);
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(25 * 4000);
    error_cnt++;
    finish_test;
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    acc(1, 8'hdd, 8'h06, 0, 1, 8'h07);
    acc(0, 8'hdc, 8'h05, 8'hc3, 1, 0);
    acc(1, 8'hdd, 8'h05, 0, 1, 8'h3c);
    acc(0, 8'hdd, 8'h06, 8'h22, 0, 0);
    acc(1, 8'hdc, 8'h06, 0, 0, 0);
    acc(0, 8'hdc, 8'h06, 8'h10, 1, 0);
    acc(1, 8'hdd, 8'h06, 0, 1, 8'h10);
    for (int m = 0; m < 2; m++) begin
      acc(0, 8'hdc, 8'h00, m ? 8'h87 : 8'h07, 1, 0);
      power_down_n = 1'b0;
      repeat (40) @(negedge sys_clk);
      chk("pll_en", 8'h00, {7'h0, pll_en});
      chk("comp_oe", 8'h00, c_oe);
      chk("true_oe", m ? 8'h00 : 8'hff, t_oe);
      power_down_n = 1'b1;
      for (k = 0; k < 300 && lock !== 1'b1; k++) @(negedge sys_clk);
      chk("lock", 8'h01, {7'h0, lock});
    end
    acc(0, 8'hdc, 8'h02, 8'h0f, 1, 0);
    for (int m = 0; m < 2; m++) begin
      acc(0, 8'hdc, 8'h00, m ? 8'h47 : 8'h07, 1, 0);
      output_halt_n = 1'b0;
      repeat (40) @(negedge sys_clk);
      chk("comp_oe", 8'hf0, c_oe);
      chk("true_oe", m ? 8'hf0 : 8'hff, t_oe);
      chk("true_lo", m ? 8'h00 : 8'h0f, t & 8'h0f);
      chk("comp_lo", 8'h00, c & 8'h0f);
      output_halt_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk("true_oe", 8'hff, t_oe);
      repeat (64) @(negedge sys_clk);
      chk("comp_oe", 8'hff, c_oe);
    end
    acc(0, 8'hdc, 8'h00, 8'h07, 1, 0);
    power_down_n = 1'b0;
    output_halt_n = 1'b0;
    repeat (40) @(negedge sys_clk);
    chk("comp_oe", 8'h00, c_oe);
    chk("true_oe", 8'hff, t_oe);
    power_down_n = 1'b1;
    output_halt_n = 1'b1;
    repeat (200) @(negedge sys_clk);
    finish_test;
  end
endmodule // clock_buffer_power_stop_control_tb_top
